// ---- hdl/udr_pkg.sv ----
// Operation
// RULE1 - Each channel pulls its receive-ready output low when at least one received character waits; in block mode the code waits for the trigger level.
// RULE2 - Receive-ready goes high when the receive buffer is empty or the trigger level is not reached.
// RULE3 - Each channel pulls its transmit-ready output low while a free transmit location exists; in mode 0 the code waits until the transmit buffer is empty.
// RULE4 - In block mode the transmit-ready output goes high once the transmit buffer is full.
// RULE5 - Both ready outputs serve single-transfer mode 0 as well as block mode 1.
// RULE6 - The serial output rests high under reset, while idle and while the transmitter is off.
// RULE7 - In local loopback the serial output is held off and the transmit stream feeds the receiver.
// RULE8 - In local loopback the external serial input is ignored by the receiver.
// RULE9 - Control bit 0 enables the 16-entry buffers and bits 7:6 select the receive trigger.
// RULE10 - The receive trigger levels are 1, 4, 8 and 14 characters.
// RULE11 - In mode 0 transmit-ready rises after one write and receive-ready rises once emptied.
`default_nettype none

package udr_pkg;

	// ----------------------------------------
	// sizes and timing
	// ----------------------------------------
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned CNT_W = $clog2(FIFO_DEPTH + 1);
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned BAUD_HZ = 115_200;
	localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_HZ;
	localparam int unsigned TIMER_W = 16;

	// ----------------------------------------
	// register indexes (addr[2:0]); addr[3] picks the channel
	// ----------------------------------------
	localparam logic [2:0] REG_DATA = 3'h0;
	localparam logic [2:0] REG_FIFO_CTRL = 3'h2;
	localparam logic [2:0] REG_LINE_CTRL = 3'h4;
	localparam logic [2:0] REG_LINE_STAT = 3'h5;
	localparam logic [2:0] REG_SCRATCH = 3'h7;

	// ----------------------------------------
	// fifo_control_reg fields
	// ----------------------------------------
	localparam int unsigned FCR_FIFO_EN_BIT = 0;
	localparam int unsigned FCR_RX_FLUSH_BIT = 1;
	localparam int unsigned FCR_TX_FLUSH_BIT = 2;
	localparam int unsigned FCR_DMA_MODE_BIT = 3;
	localparam int unsigned FCR_TRIG_LSB = 6;
	localparam logic [7:0] FCR_KEEP_MASK = 8'hC9;
	localparam logic [7:0] FCR_RST = 8'h00;

	// ----------------------------------------
	// line control fields
	// ----------------------------------------
	localparam int unsigned LC_LOOP_BIT = 4;
	localparam int unsigned LC_TX_EN_BIT = 5;
	localparam logic [7:0] LC_KEEP_MASK = 8'h3F;
	localparam logic [7:0] LC_RST = 8'h20;
	localparam logic [7:0] SCRATCH_RST = 8'h00;

	// ----------------------------------------
	// line status fields
	// ----------------------------------------
	localparam int unsigned LS_DATA_RDY_BIT = 0;
	localparam int unsigned LS_OVERRUN_BIT = 1;
	localparam int unsigned LS_FRAMING_BIT = 3;
	localparam int unsigned LS_TX_EMPTY_BIT = 5;
	localparam int unsigned LS_TX_IDLE_BIT = 6;
	localparam logic [7:0] ID_NO_PEND = 8'h01;
	localparam logic [7:0] ID_FIFO_ON = 8'hC0;

	// ----------------------------------------
	// trigger levels
	// ----------------------------------------
	localparam logic [CNT_W-1:0] TRIG_L0 = 5'h01;
	localparam logic [CNT_W-1:0] TRIG_L1 = 5'h04;
	localparam logic [CNT_W-1:0] TRIG_L2 = 5'h08;
	localparam logic [CNT_W-1:0] TRIG_L3 = 5'h0E;

	function automatic logic [CNT_W-1:0] udr_trig_level(input logic [1:0] code);
		unique case (code)
			2'h0: return TRIG_L0; // RULE10
			2'h1: return TRIG_L1; // RULE10
			2'h2: return TRIG_L2; // RULE10
			2'h3: return TRIG_L3; // RULE10
		endcase
	endfunction : udr_trig_level

endpackage : udr_pkg

`default_nettype wire

// ---- hdl/udr_fifo_if.sv ----
`default_nettype none

interface udr_fifo_if #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned CW = 5
);
	logic push;
	logic [WIDTH-1:0] push_data;
	logic flush;
	logic one_deep;
	logic pop;
	logic [WIDTH-1:0] head;
	logic [CW-1:0] count;
	logic full;

	modport store(input push, push_data, flush, one_deep, pop, output head, count, full);
	modport writer(output push, push_data, flush, one_deep, input count, full);
	modport reader(output pop, input head, count);
endinterface : udr_fifo_if

`default_nettype wire

// ---- hdl/udr_fifo.sv ----
`default_nettype none

module udr_fifo
	import udr_pkg::*;
#(
	parameter int unsigned WIDTH = DATA_W,
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_ce,
	udr_fifo_if.store q
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
	logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
	logic [CW-1:0] count_ff, nxt_count;
	logic full_int;
	logic do_push;
	logic do_pop;

	function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : step

	// one entry only while the buffers are switched off
	assign full_int = q.one_deep ? (count_ff != '0) : (count_ff == CW'(DEPTH)); // RULE9
	assign do_push = q.push && !full_int;
	assign do_pop = q.pop && (count_ff != '0);

	always_comb begin
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		nxt_count = count_ff;
		if (q.flush) begin
			nxt_wr_ptr = '0;
			nxt_rd_ptr = '0;
			nxt_count = '0;
		end else begin
			if (do_push) begin
				nxt_wr_ptr = step(wr_ptr_ff);
			end
			if (do_pop) begin
				nxt_rd_ptr = step(rd_ptr_ff);
			end
			if (do_push && !do_pop) begin
				nxt_count = CW'(count_ff + 1'b1);
			end else if (do_pop && !do_push) begin
				nxt_count = CW'(count_ff - 1'b1);
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else if (i_ce) begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff <= nxt_count;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_ce && do_push && !q.flush) begin
			mem_ff[wr_ptr_ff] <= q.push_data;
		end
	end

	assign q.head = mem_ff[rd_ptr_ff];
	assign q.count = count_ff;
	assign q.full = full_int;

endmodule : udr_fifo

`default_nettype wire

// ---- hdl/udr_tx_line.sv ----
`default_nettype none

module udr_tx_line
	import udr_pkg::*;
#(
	parameter int unsigned BIT_CYC = BIT_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic i_enable,
	udr_fifo_if.reader src,
	output logic o_bit,
	output logic o_busy
);
	typedef enum logic [3:0] {
		T_IDLE = 4'b0001,
		T_START = 4'b0010,
		T_DATA = 4'b0100,
		T_STOP = 4'b1000
	} udr_tx_state_e;

	udr_tx_state_e state_ff, nxt_state;
	logic [TIMER_W-1:0] cnt_ff, nxt_cnt;
	logic [2:0] bitn_ff, nxt_bitn;
	logic [DATA_W-1:0] shift_ff, nxt_shift;
	logic bit_ff, nxt_bit;
	logic take;

	// disabled transmitter starts no new character
	assign take = (state_ff == T_IDLE) && i_enable && (src.count != '0); // RULE6

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = (cnt_ff != '0) ? TIMER_W'(cnt_ff - 1'b1) : cnt_ff;
		nxt_bitn = bitn_ff;
		nxt_shift = shift_ff;
		nxt_bit = bit_ff;
		unique case (state_ff)
			T_IDLE: begin
				nxt_bit = 1'b1; // RULE6
				if (take) begin
					nxt_state = T_START;
					nxt_shift = src.head;
					nxt_cnt = TIMER_W'(BIT_CYC - 1);
					nxt_bitn = '0;
					nxt_bit = 1'b0;
				end
			end
			T_START: begin
				if (cnt_ff == '0) begin
					nxt_state = T_DATA;
					nxt_cnt = TIMER_W'(BIT_CYC - 1);
					nxt_bit = shift_ff[0];
				end
			end
			T_DATA: begin
				if (cnt_ff == '0) begin
					nxt_cnt = TIMER_W'(BIT_CYC - 1);
					if (bitn_ff == 3'h7) begin
						nxt_state = T_STOP;
						nxt_bit = 1'b1;
					end else begin
						nxt_bitn = 3'(bitn_ff + 1'b1);
						nxt_shift = {1'b0, shift_ff[DATA_W-1:1]};
						nxt_bit = shift_ff[1];
					end
				end
			end
			T_STOP: begin
				if (cnt_ff == '0) begin
					nxt_state = T_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			state_ff <= T_IDLE;
			cnt_ff <= '0;
			bitn_ff <= '0;
			shift_ff <= '0;
			bit_ff <= 1'b1;
		end else if (i_ce) begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			bitn_ff <= nxt_bitn;
			shift_ff <= nxt_shift;
			bit_ff <= nxt_bit;
		end
	end

	assign src.pop = take && i_ce;
	assign o_bit = bit_ff;
	assign o_busy = (state_ff != T_IDLE);

endmodule : udr_tx_line

`default_nettype wire

// ---- hdl/udr_top.sv ----
`default_nettype none

module udr_top
	import udr_pkg::*;
#(
	parameter int unsigned BIT_CYC = BIT_CYCLES,
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_serial_in_chan_a,
	input wire logic i_serial_in_chan_b,
	output logic o_serial_out_chan_a,
	output logic o_serial_out_chan_b,
	output logic o_rx_avail_n_chan_a,
	output logic o_rx_avail_n_chan_b,
	output logic o_tx_space_n_chan_a,
	output logic o_tx_space_n_chan_b
);
	localparam int unsigned NCH = 2;
	localparam int unsigned HALF_CYC = (BIT_CYC + 1) / 2;

	typedef enum logic [3:0] {
		R_IDLE = 4'b0001,
		R_START = 4'b0010,
		R_DATA = 4'b0100,
		R_STOP = 4'b1000
	} udr_rx_state_e;

	logic [NCH-1:0] pin_in;
	logic [NCH-1:0] line_ff;
	logic [NCH-1:0] rx_avail_n_ff;
	logic [NCH-1:0] tx_space_n_ff;
	logic [7:0] rd_val [NCH];
	logic [7:0] rdata_ff, nxt_rdata;

	function automatic logic reg_hit(input logic [3:0] addr, input logic ch,
			input logic [2:0] idx);
		return (addr[3] == ch) && (addr[2:0] == idx);
	endfunction : reg_hit

	assign pin_in = {i_serial_in_chan_b, i_serial_in_chan_a};

	// ----------------------------------------
	// per-channel logic
	// ----------------------------------------
	for (genvar ch = 0; ch < NCH; ch++) begin : gen_ch
		udr_fifo_if #(.WIDTH(DATA_W), .CW(CNT_W)) tx_q ();
		udr_fifo_if #(.WIDTH(DATA_W), .CW(CNT_W)) rx_q ();

		logic [7:0] fcr_ff, nxt_fcr;
		logic [7:0] lc_ff, nxt_lc;
		logic [7:0] spr_ff, nxt_spr;
		logic ovr_ff, nxt_ovr;
		logic frm_ff, nxt_frm;
		logic pin_meta_ff, pin_sync_ff;
		udr_rx_state_e rx_state_ff, nxt_rx_state;
		logic [TIMER_W-1:0] rx_cnt_ff, nxt_rx_cnt;
		logic [2:0] rx_bitn_ff, nxt_rx_bitn;
		logic [DATA_W-1:0] rx_shift_ff, nxt_rx_shift;
		logic rx_push;
		logic ovr_set;
		logic frm_set;
		logic rx_in;
		logic tx_bit;
		logic tx_busy;
		logic fifo_en;
		logic block_mode;
		logic loop_on;
		logic wr_fcr;
		logic wr_data;
		logic rd_data;
		logic rd_stat;
		logic [CNT_W-1:0] trig;
		logic nxt_line;
		logic nxt_rx_avail_n;
		logic nxt_tx_space_n;

		assign wr_fcr = i_wr && reg_hit(i_addr, 1'(ch), REG_FIFO_CTRL);
		assign wr_data = i_wr && reg_hit(i_addr, 1'(ch), REG_DATA);
		assign rd_data = i_rd && reg_hit(i_addr, 1'(ch), REG_DATA);
		assign rd_stat = i_rd && reg_hit(i_addr, 1'(ch), REG_LINE_STAT);
		assign fifo_en = fcr_ff[FCR_FIFO_EN_BIT]; // RULE9
		assign block_mode = fifo_en && fcr_ff[FCR_DMA_MODE_BIT]; // RULE5
		assign loop_on = lc_ff[LC_LOOP_BIT];
		// buffers off: holding register acts as a one-deep store
		assign trig = fifo_en ? udr_trig_level(fcr_ff[7:6]) : TRIG_L0; // RULE9

		// ----------------------------------------
		// buffers and transmitter
		// ----------------------------------------
		udr_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
			.i_clk_sys(i_clk_sys),
			.i_reset(i_reset),
			.i_ce(i_ce),
			.q(tx_q.store)
		);

		udr_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
			.i_clk_sys(i_clk_sys),
			.i_reset(i_reset),
			.i_ce(i_ce),
			.q(rx_q.store)
		);

		udr_tx_line #(.BIT_CYC(BIT_CYC)) u_tx_line (
			.i_clk_sys(i_clk_sys),
			.i_reset(i_reset),
			.i_ce(i_ce),
			.i_enable(lc_ff[LC_TX_EN_BIT]),
			.src(tx_q.reader),
			.o_bit(tx_bit),
			.o_busy(tx_busy)
		);

		// switching the buffers on or off empties both
		assign tx_q.push = wr_data && i_ce;
		assign tx_q.push_data = i_wdata;
		assign tx_q.flush = wr_fcr && i_ce &&
			(i_wdata[FCR_TX_FLUSH_BIT] || (i_wdata[FCR_FIFO_EN_BIT] != fifo_en)); // RULE9
		assign tx_q.one_deep = !fifo_en;
		assign rx_q.push = rx_push && i_ce;
		assign rx_q.push_data = rx_shift_ff;
		assign rx_q.flush = wr_fcr && i_ce &&
			(i_wdata[FCR_RX_FLUSH_BIT] || (i_wdata[FCR_FIFO_EN_BIT] != fifo_en)); // RULE9
		assign rx_q.one_deep = !fifo_en;
		assign rx_q.pop = rd_data && i_ce;

		// ----------------------------------------
		// control registers and sticky errors
		// ----------------------------------------
		always_comb begin
			nxt_fcr = fcr_ff;
			nxt_lc = lc_ff;
			nxt_spr = spr_ff;
			if (wr_fcr) begin
				nxt_fcr = i_wdata & FCR_KEEP_MASK; // RULE9
			end
			if (i_wr && reg_hit(i_addr, 1'(ch), REG_LINE_CTRL)) begin
				nxt_lc = i_wdata & LC_KEEP_MASK;
			end
			if (i_wr && reg_hit(i_addr, 1'(ch), REG_SCRATCH)) begin
				nxt_spr = i_wdata;
			end
			// a new error beats the clearing read
			nxt_ovr = (ovr_ff && !rd_stat) || ovr_set;
			nxt_frm = (frm_ff && !rd_stat) || frm_set;
		end

		always_ff @(posedge i_clk_sys or posedge i_reset) begin
			if (i_reset) begin
				fcr_ff <= FCR_RST;
				lc_ff <= LC_RST;
				spr_ff <= SCRATCH_RST;
				ovr_ff <= 1'b0;
				frm_ff <= 1'b0;
			end else if (i_ce) begin
				fcr_ff <= nxt_fcr;
				lc_ff <= nxt_lc;
				spr_ff <= nxt_spr;
				ovr_ff <= nxt_ovr;
				frm_ff <= nxt_frm;
			end
		end

		// ----------------------------------------
		// serial input synchroniser and receiver
		// ----------------------------------------
		always_ff @(posedge i_clk_sys or posedge i_reset) begin
			if (i_reset) begin
				pin_meta_ff <= 1'b1;
				pin_sync_ff <= 1'b1;
			end else if (i_ce) begin
				pin_meta_ff <= pin_in[ch];
				pin_sync_ff <= pin_meta_ff;
			end
		end

		assign rx_in = loop_on ? tx_bit : pin_sync_ff; // RULE7 RULE8

		always_comb begin
			nxt_rx_state = rx_state_ff;
			nxt_rx_cnt = (rx_cnt_ff != '0) ? TIMER_W'(rx_cnt_ff - 1'b1) : rx_cnt_ff;
			nxt_rx_bitn = rx_bitn_ff;
			nxt_rx_shift = rx_shift_ff;
			rx_push = 1'b0;
			ovr_set = 1'b0;
			frm_set = 1'b0;
			unique case (rx_state_ff)
				R_IDLE: begin
					if (!rx_in) begin
						nxt_rx_state = R_START;
						nxt_rx_cnt = TIMER_W'(HALF_CYC - 1);
					end
				end
				R_START: begin
					if (rx_cnt_ff == '0) begin
						// glitch shorter than half a bit is dropped
						nxt_rx_state = rx_in ? R_IDLE : R_DATA;
						nxt_rx_cnt = TIMER_W'(BIT_CYC - 1);
						nxt_rx_bitn = '0;
					end
				end
				R_DATA: begin
					if (rx_cnt_ff == '0) begin
						nxt_rx_shift = {rx_in, rx_shift_ff[DATA_W-1:1]};
						nxt_rx_cnt = TIMER_W'(BIT_CYC - 1);
						nxt_rx_bitn = 3'(rx_bitn_ff + 1'b1);
						if (rx_bitn_ff == 3'h7) begin
							nxt_rx_state = R_STOP;
						end
					end
				end
				R_STOP: begin
					if (rx_cnt_ff == '0) begin
						nxt_rx_state = R_IDLE;
						if (!rx_in) begin
							frm_set = 1'b1;
						end else if (rx_q.full) begin
							ovr_set = 1'b1;
						end else begin
							rx_push = 1'b1;
						end
					end
				end
			endcase
		end

		always_ff @(posedge i_clk_sys or posedge i_reset) begin
			if (i_reset) begin
				rx_state_ff <= R_IDLE;
				rx_cnt_ff <= '0;
				rx_bitn_ff <= '0;
				rx_shift_ff <= '0;
			end else if (i_ce) begin
				rx_state_ff <= nxt_rx_state;
				rx_cnt_ff <= nxt_rx_cnt;
				rx_bitn_ff <= nxt_rx_bitn;
				rx_shift_ff <= nxt_rx_shift;
			end
		end

		// ----------------------------------------
		// pins: serial line and ready outputs
		// ----------------------------------------
		always_comb begin
			nxt_line = 1'b1; // RULE6
			if (!loop_on && lc_ff[LC_TX_EN_BIT]) begin // RULE7
				nxt_line = tx_bit; // RULE6
			end
			if (block_mode) begin
				nxt_rx_avail_n = (rx_q.count < trig); // RULE1 RULE2 RULE5
				nxt_tx_space_n = tx_q.full; // RULE3 RULE4 RULE5
			end else begin
				nxt_rx_avail_n = (rx_q.count == '0); // RULE1 RULE2 RULE11
				nxt_tx_space_n = (tx_q.count != '0); // RULE3 RULE11
			end
		end

		always_ff @(posedge i_clk_sys or posedge i_reset) begin
			if (i_reset) begin
				line_ff[ch] <= 1'b1; // RULE6
				rx_avail_n_ff[ch] <= 1'b1;
				tx_space_n_ff[ch] <= 1'b1;
			end else if (i_ce) begin
				line_ff[ch] <= nxt_line;
				rx_avail_n_ff[ch] <= nxt_rx_avail_n;
				tx_space_n_ff[ch] <= nxt_tx_space_n;
			end
		end

		// ----------------------------------------
		// read values
		// ----------------------------------------
		always_comb begin
			rd_val[ch] = 8'h00;
			unique case (i_addr[2:0])
				REG_DATA: rd_val[ch] = (rx_q.count != '0) ? rx_q.head : 8'h00;
				REG_FIFO_CTRL: rd_val[ch] = fifo_en ? (ID_NO_PEND | ID_FIFO_ON) : ID_NO_PEND;
				REG_LINE_CTRL: rd_val[ch] = lc_ff;
				REG_LINE_STAT: begin
					rd_val[ch][LS_DATA_RDY_BIT] = (rx_q.count != '0);
					rd_val[ch][LS_OVERRUN_BIT] = ovr_ff;
					rd_val[ch][LS_FRAMING_BIT] = frm_ff;
					rd_val[ch][LS_TX_EMPTY_BIT] = (tx_q.count == '0);
					rd_val[ch][LS_TX_IDLE_BIT] = (tx_q.count == '0) && !tx_busy;
				end
				REG_SCRATCH: rd_val[ch] = spr_ff;
				default: rd_val[ch] = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// read data, one cycle after the strobe
	// ----------------------------------------
	always_comb begin
		nxt_rdata = 8'h00;
		if (i_rd) begin
			nxt_rdata = rd_val[i_addr[3]];
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			rdata_ff <= 8'h00;
		end else if (i_ce) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_serial_out_chan_a = line_ff[0];
	assign o_serial_out_chan_b = line_ff[1];
	assign o_rx_avail_n_chan_a = rx_avail_n_ff[0];
	assign o_rx_avail_n_chan_b = rx_avail_n_ff[1];
	assign o_tx_space_n_chan_a = tx_space_n_ff[0];
	assign o_tx_space_n_chan_b = tx_space_n_ff[1];

endmodule : udr_top

`default_nettype wire

// ---- verification/udr_top_checker.sv ----
`default_nettype none

module udr_top_checker
	import udr_pkg::*;
#(
	parameter int unsigned BIT_CYC = BIT_CYCLES,
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic i_serial_in_chan_a,
	input wire logic i_serial_in_chan_b,
	input wire logic o_serial_out_chan_a,
	input wire logic o_serial_out_chan_b,
	input wire logic o_rx_avail_n_chan_a,
	input wire logic o_rx_avail_n_chan_b,
	input wire logic o_tx_space_n_chan_a,
	input wire logic o_tx_space_n_chan_b
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// channel a control shadow and frame position
	// ----------------------------------------
	logic loop_ff, txen_ff, blk_ff, prev_ff, act_ff;
	logic nxt_loop, nxt_txen, nxt_blk, nxt_prev, nxt_act;
	logic [15:0] cnt_ff, nxt_cnt;
	logic wa, wb, ta, tb, ra, rb;

	always_comb begin
		wa = i_ce && i_wr && !i_addr[3];
		wb = i_ce && i_wr && i_addr[3];
		ta = wa && (i_addr[2:0] == REG_DATA || i_addr[2:0] == REG_FIFO_CTRL);
		tb = wb && (i_addr[2:0] == REG_DATA || i_addr[2:0] == REG_FIFO_CTRL);
		ra = (i_ce && i_rd && i_addr == 4'h0) || (wa && i_addr[2:0] == REG_FIFO_CTRL);
		rb = (i_ce && i_rd && i_addr == 4'h8) || (wb && i_addr[2:0] == REG_FIFO_CTRL);
		nxt_loop = loop_ff;
		nxt_txen = txen_ff;
		nxt_blk = blk_ff;
		if (wa && i_addr[2:0] == REG_LINE_CTRL) begin
			nxt_loop = i_wdata[LC_LOOP_BIT];
			nxt_txen = i_wdata[LC_TX_EN_BIT];
		end
		if (wa && i_addr[2:0] == REG_FIFO_CTRL)
			nxt_blk = i_wdata[FCR_DMA_MODE_BIT] & i_wdata[FCR_FIFO_EN_BIT];
		nxt_prev = o_serial_out_chan_a;
		nxt_act = act_ff;
		nxt_cnt = cnt_ff + 16'h0001;
		if (!act_ff) begin
			nxt_act = prev_ff && !o_serial_out_chan_a;
			nxt_cnt = 16'h0001;
		end else if (cnt_ff == 16'(10 * BIT_CYC - 1))
			nxt_act = 1'b0;
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			loop_ff <= 1'b0;
			txen_ff <= 1'b1;
			blk_ff <= 1'b0;
			prev_ff <= 1'b1;
			act_ff <= 1'b0;
			cnt_ff <= 16'h0000;
		end else if (i_ce) begin
			loop_ff <= nxt_loop;
			txen_ff <= nxt_txen;
			blk_ff <= nxt_blk;
			prev_ff <= nxt_prev;
			act_ff <= nxt_act;
			cnt_ff <= nxt_cnt;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	sequence s_push_a;
		wa && i_addr[2:0] == REG_DATA && !blk_ff;
	endsequence
	sequence s_space_up;
		##[1:3] o_tx_space_n_chan_a;
	endsequence

	a_reset_ready: assert property (
		$fell(i_reset) |-> o_rx_avail_n_chan_a && o_rx_avail_n_chan_b
		##[0:1] !o_tx_space_n_chan_a && !o_tx_space_n_chan_b) else $error("ready after reset");
	a_loop_line_high: assert property (
		$past(loop_ff) && loop_ff |-> o_serial_out_chan_a) else $error("line low in loopback");
	a_txoff_line_high: assert property (
		!$past(txen_ff) && !txen_ff |-> o_serial_out_chan_a) else $error("line low while off");
	a_stop_bit_high: assert property (
		act_ff && cnt_ff >= 9 * BIT_CYC |-> o_serial_out_chan_a) else $error("stop bit low");
	a_mode0_space: assert property (
		s_push_a |-> s_space_up) else $error("tx ready stays low after write");
	a_space_a_cause: assert property (
		$rose(o_tx_space_n_chan_a) |-> $past(ta, 2) || $past(ta, 3)) else $error("tx ready a rose");
	a_space_b_cause: assert property (
		$rose(o_tx_space_n_chan_b) |-> $past(tb, 2) || $past(tb, 3)) else $error("tx ready b rose");
	a_avail_a_cause: assert property (
		$rose(o_rx_avail_n_chan_a) |-> $past(ra, 2) || $past(ra, 3)) else $error("rx ready a rose");
	a_avail_b_cause: assert property (
		$rose(o_rx_avail_n_chan_b) |-> $past(rb, 2) || $past(rb, 3)) else $error("rx ready b rose");
endmodule : udr_top_checker

bind udr_top udr_top_checker #(.BIT_CYC(BIT_CYC), .DEPTH(DEPTH)) u_chk (
	.i_clk_sys, .i_reset, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
	.i_serial_in_chan_a, .i_serial_in_chan_b, .o_serial_out_chan_a, .o_serial_out_chan_b,
	.o_rx_avail_n_chan_a, .o_rx_avail_n_chan_b, .o_tx_space_n_chan_a, .o_tx_space_n_chan_b);

`default_nettype wire

// ---- verification/udr_serial_peer.sv ----
`default_nettype none

module udr_serial_peer #(
	parameter int BC = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_line_a,
	input wire logic i_line_b,
	output logic o_line_a,
	output logic o_line_b
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		o_line_a = 1'b1;
		o_line_b = 1'b1;
	end

	task automatic jam(input bit ch, input logic v);
		if (ch)
			o_line_b <= v;
		else
			o_line_a <= v;
	endtask : jam

	// 8 data bits lsb first, one stop bit
	task automatic send(input bit ch, input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge i_clk_sys);
			jam(ch, f[i]);
			repeat (BC - 1) @(posedge i_clk_sys);
		end
	endtask : send

	task automatic recv(input bit ch, input int lim, output logic [7:0] d, output bit ok);
		int n;
		n = 0;
		ok = 1'b0;
		d = 8'h00;
		while ((ch ? i_line_b : i_line_a) !== 1'b0 && n < lim) begin
			@(posedge i_clk_sys);
			n++;
		end
		if (n >= lim)
			return;
		repeat (BC / 2) @(posedge i_clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (BC) @(posedge i_clk_sys);
			d[i] = ch ? i_line_b : i_line_a;
		end
		repeat (BC) @(posedge i_clk_sys);
		ok = (ch ? i_line_b : i_line_a) === 1'b1;
	endtask : recv
endmodule : udr_serial_peer

`default_nettype wire

// ---- verification/tb_top.sv ----
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BC = 8;
	logic i_clk_sys, i_reset, i_wr, i_rd, i_ce;
	logic [3:0] i_addr;
	logic [7:0] i_wdata, o_rdata;
	logic ln_a, ln_b, out_a, out_b, av_a, av_b, sp_a, sp_b;
	int bad_count, checked;

	udr_top #(.BIT_CYC(BC), .DEPTH(16)) dut (
		.i_clk_sys, .i_reset, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_serial_in_chan_a(ln_a), .i_serial_in_chan_b(ln_b),
		.o_serial_out_chan_a(out_a), .o_serial_out_chan_b(out_b),
		.o_rx_avail_n_chan_a(av_a), .o_rx_avail_n_chan_b(av_b),
		.o_tx_space_n_chan_a(sp_a), .o_tx_space_n_chan_b(sp_b));
	udr_serial_peer #(.BC(BC)) peer (.i_clk_sys, .i_line_a(out_a), .i_line_b(out_b),
		.o_line_a(ln_a), .o_line_b(ln_b));

	// ----------------------------------------
	// compare, bus and closing tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("bad_count=%0d checked=%0d", bad_count, checked);
		if (bad_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	task automatic cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t pin %b want %b", $time, got, exp);
		end
	endtask : cmp_bit

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t byte %h want %h", $time, got, exp);
		end
	endtask : cmp_byte

	task automatic settle(input int n);
		repeat (n) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
	endtask : settle

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		@(negedge i_clk_sys);
		d = o_rdata;
	endtask : rd

	task automatic get(input bit ch, input logic [7:0] exp);
		logic [7:0] d;
		bit ok;
		peer.recv(ch, 30 * BC, d, ok);
		if (!ok) begin
			bad_count++;
			$display("CHECK FAILED t=%0t no frame", $time);
		end
		cmp_byte(d, exp);
	endtask : get

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_state();
		cmp_bit(out_a & out_b, 1'b1);
		cmp_bit(av_a & av_b, 1'b1);
		@(posedge i_clk_sys);
		i_reset <= 1'b0;
		settle(2);
		cmp_bit(sp_a | sp_b, 1'b0);
		// frozen clock enable: the write must not land
		@(posedge i_clk_sys);
		i_ce <= 1'b0;
		wr(4'h8, 8'h11);
		settle(2);
		cmp_bit(sp_b | !out_b, 1'b0);
		@(posedge i_clk_sys);
		i_ce <= 1'b1;
	endtask : t_reset_state

	task automatic t_single_tx();
		wr(4'h4, 8'h00);
		wr(4'h0, 8'hA5);
		settle(3);
		cmp_bit(sp_a, 1'b1);
		cmp_bit(out_a, 1'b1);
		wr(4'h4, 8'h20);
		get(0, 8'hA5);
		settle(2);
		cmp_bit(sp_a, 1'b0);
	endtask : t_single_tx

	task automatic t_single_rx();
		logic [7:0] d;
		peer.send(1, 8'h3C);
		settle(2);
		cmp_bit(av_b, 1'b0);
		rd(4'hD, d);
		cmp_byte(d, 8'h61);
		rd(4'h8, d);
		cmp_byte(d, 8'h3C);
		settle(2);
		cmp_bit(av_b, 1'b1);
	endtask : t_single_rx

	task automatic t_block_trig();
		int lvl[4];
		lvl = '{1, 4, 8, 14};
		for (int c = 0; c < 4; c++) begin
			wr(4'hA, {c[1:0], 6'h0B});
			for (int k = 1; k < lvl[c]; k++)
				peer.send(1, k[7:0]);
			settle(2);
			cmp_bit(av_b, 1'b1);
			peer.send(1, 8'h77);
			settle(2);
			cmp_bit(av_b, 1'b0);
		end
		wr(4'hA, 8'h02);
	endtask : t_block_trig

	task automatic t_block_tx();
		logic [7:0] d;
		bit ok;
		wr(4'h4, 8'h00);
		wr(4'h2, 8'h09);
		for (int k = 0; k < 16; k++) begin
			settle(2);
			cmp_bit(sp_a, 1'b0);
			wr(4'h0, k[7:0]);
		end
		wr(4'h0, 8'hEE);
		settle(2);
		cmp_bit(sp_a, 1'b1);
		wr(4'h4, 8'h20);
		for (int k = 0; k < 16; k++)
			get(0, k[7:0]);
		peer.recv(0, 20 * BC, d, ok);
		cmp_bit(ok, 1'b0);
		wr(4'h2, 8'h00);
	endtask : t_block_tx

	task automatic t_loop();
		logic [7:0] d;
		logic low;
		low = 1'b0;
		wr(4'h4, 8'h30);
		peer.jam(0, 1'b0);
		wr(4'h0, 8'h5A);
		repeat (12 * BC) begin
			@(negedge i_clk_sys);
			low = low | !out_a;
		end
		cmp_bit(low, 1'b0);
		cmp_bit(av_a, 1'b0);
		rd(4'h0, d);
		cmp_byte(d, 8'h5A);
		@(posedge i_clk_sys);
		peer.jam(0, 1'b1);
		wr(4'h4, 8'h20);
	endtask : t_loop

	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end

	initial begin
		i_reset = 1'b1;
		i_ce = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		bad_count = 0;
		checked = 0;
		settle(2);
		t_reset_state();
		t_single_tx();
		t_single_rx();
		t_block_trig();
		t_block_tx();
		t_loop();
		stop_test();
	end
endmodule : tb_top

`default_nettype wire
